// >>> rtl/rsc_cfg.svh
// Constants of the reset source controller: offsets, fields, codes, timing
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------------
`define RSC_OFS_CAUSE   12'h000
`define RSC_OFS_SYS3    12'h004
`define RSC_OFS_COMMIT  12'h008
`define RSC_OFS_STATE   12'h00C

// ----------------------------------------------------------------------
// Field positions, codes and reset values
// ----------------------------------------------------------------------
`define RSC_BIT_CLR     7
`define RSC_BIT_DIS     0
`define RSC_CODE_CLR    8'h71
`define RSC_CODE_PIN    8'hB2
`define RSC_VECTOR      17'h1FFFE
`define RSC_CAUSE_RST   3'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RSC_CLK_NS      4
`define RSC_PIN_LOW_NS  5000
`define RSC_PIN_LOW_CYC ((`RSC_PIN_LOW_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`define RSC_WARMUP_CYC  1024
`define RSC_INT_RST_CYC 4'h4

`endif

// >>> rtl/rsc_pkg.sv
// Types of the reset source controller
package rsc_pkg;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RSC_HELD   = 2'b00,
        RSC_WARMUP = 2'b01,
        RSC_SHADOW = 2'b10,
        RSC_RUN    = 2'b11
    } rsc_state_t;

    // ------------------------------------------------------------------
    // Internal factor events: deadlock, watchdog, voltage detect
    // ------------------------------------------------------------------
    typedef struct packed {
        logic dead;
        logic wdt;
        logic vdet;
    } rsc_cause_t;

    // ------------------------------------------------------------------
    // Whole state of the controller
    // ------------------------------------------------------------------
    typedef struct packed {
        rsc_state_t  state;
        logic [15:0] warm_cnt;
        logic [15:0] pin_cnt;
        logic [3:0]  int_cnt;
        rsc_cause_t  cause;
        logic        clr_req;
        logic        pin_dis;
        logic        pin_port;
        logic        por_q;
        logic        port_q;
        logic [31:0] rdata;
    } rsc_regs_t;

endpackage : rsc_pkg

// >>> rtl/rsc_ctrl.sv
// Reset source combining, warm-up sequencing and cause recording
`timescale 1ns/1ps
`include "rsc_cfg.svh"

module rsc_ctrl #(
    parameter int WARMUP_CYCLES  = `RSC_WARMUP_CYC,
    parameter int PIN_LOW_CYCLES = `RSC_PIN_LOW_CYC
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // APB slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Supply and shared pin
    input  wire logic        supply_good,
    input  wire logic        shared_reset_port_pin,
    // Internal factor sources
    input  wire logic        vdet_reset_req,
    input  wire logic        wdt_overflow,
    input  wire logic        clock_deadlock_flag,
    // Shadow RAM copy handshake
    input  wire logic        shadow_copy_done,
    output logic             shadow_copy_req,
    // Status towards CPU and peripherals
    output logic             por_active,
    output logic             cpu_hold,
    output logic             warmup_active,
    output logic             cpu_run,
    output logic      [16:0] reset_vector,
    output logic             reset_pin_is_port,
    output logic             port_pin_value
);

    // ------------------------------------------------------------------
    // State and decode
    // ------------------------------------------------------------------
    rsc_pkg::rsc_regs_t st_ff;
    rsc_pkg::rsc_regs_t nxt_st;
    logic               wr_acc;
    logic               rd_setup;
    logic               mapped;
    logic               pin_low;
    logic               pin_rst;
    logic               ext_rst;
    logic               int_evt;
    logic               any_rst;
    logic               commit_wr;
    logic               commit_clr;
    logic               commit_pin;
    rsc_pkg::rsc_cause_t events;

    // Address decode shared by read and write paths
    always_comb begin
        mapped = (paddr == `RSC_OFS_CAUSE) || (paddr == `RSC_OFS_SYS3) ||
                 (paddr == `RSC_OFS_COMMIT) || (paddr == `RSC_OFS_STATE);
    end

    // Zero wait states; error only on unmapped access
    // Every register answers from a flop, so no stall is needed
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped;
    assign wr_acc   = psel && penable && pwrite && mapped;
    assign rd_setup = psel && !penable && !pwrite;

    // Commit register codes; other values are dropped
    assign commit_wr  = wr_acc && (paddr == `RSC_OFS_COMMIT);
    assign commit_clr = commit_wr && (pwdata[7:0] == `RSC_CODE_CLR)
                        && st_ff.clr_req;
    assign commit_pin = commit_wr && (pwdata[7:0] == `RSC_CODE_PIN);

    // ------------------------------------------------------------------
    // Reset sources
    // ------------------------------------------------------------------
    // Pin only counts as reset while it keeps its reset function
    // Restoring the reset function on a low pin arms the filter at once
    assign pin_low = !st_ff.pin_port && !shared_reset_port_pin;
    assign pin_rst = pin_low &&
                     (st_ff.pin_cnt >= 16'(PIN_LOW_CYCLES - 1));
    assign ext_rst = !supply_good || pin_rst;
    assign events  = '{dead: clock_deadlock_flag, wdt: wdt_overflow,
                       vdet: vdet_reset_req};
    assign int_evt = |events;
    assign any_rst = ext_rst || int_evt || (st_ff.int_cnt != 4'h0);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.por_q  = !supply_good;
        nxt_st.port_q = shared_reset_port_pin;

        // Glitch filter: short low pulses never reach the reset
        if (!pin_low) begin
            nxt_st.pin_cnt = 16'h0000;
        end else if (st_ff.pin_cnt < 16'(PIN_LOW_CYCLES - 1)) begin
            nxt_st.pin_cnt = st_ff.pin_cnt + 16'h0001;
        end

        // Internal reset stretched so it is seen as a real reset
        // A single-cycle pulse could slip past slower reset domains
        if (int_evt) begin
            nxt_st.int_cnt = `RSC_INT_RST_CYC;
        end else if (st_ff.int_cnt != 4'h0) begin
            nxt_st.int_cnt = st_ff.int_cnt - 4'h1;
        end

        // Cause flags: an event in the clearing cycle survives
        if (ext_rst) begin
            nxt_st.cause = `RSC_CAUSE_RST;
        end else if (commit_clr) begin
            nxt_st.cause = events;
        end else begin
            nxt_st.cause = st_ff.cause | events;
        end

        // Clear request drops itself after use
        if (ext_rst || commit_clr) begin
            nxt_st.clr_req = 1'b0;
        end else if (wr_acc && paddr == `RSC_OFS_CAUSE) begin
            nxt_st.clr_req = pwdata[`RSC_BIT_CLR];
        end

        // Staged disable bit and committed pin function
        if (!supply_good) begin
            nxt_st.pin_dis  = 1'b0;
            nxt_st.pin_port = 1'b0;
        end else begin
            if (wr_acc && paddr == `RSC_OFS_SYS3) begin
                nxt_st.pin_dis = pwdata[`RSC_BIT_DIS];
            end
            if (commit_pin) begin
                nxt_st.pin_port = st_ff.pin_dis;
            end
        end

        // Sequencer; any source restarts from the held state
        // HELD lasts one cycle after release so warm-up counts from zero
        if (any_rst) begin
            nxt_st.state    = rsc_pkg::RSC_HELD;
            nxt_st.warm_cnt = 16'h0000;
        end else begin
            case (st_ff.state)
                rsc_pkg::RSC_HELD: begin
                    nxt_st.state    = rsc_pkg::RSC_WARMUP;
                    nxt_st.warm_cnt = 16'h0000;
                end
                rsc_pkg::RSC_WARMUP: begin
                    nxt_st.warm_cnt = st_ff.warm_cnt + 16'h0001;
                    if (st_ff.warm_cnt == 16'(WARMUP_CYCLES - 1)) begin
                        nxt_st.state = rsc_pkg::RSC_SHADOW;
                    end
                end
                rsc_pkg::RSC_SHADOW: begin
                    if (shadow_copy_done) begin
                        nxt_st.state = rsc_pkg::RSC_RUN;
                    end
                end
                rsc_pkg::RSC_RUN: begin
                    nxt_st.state = rsc_pkg::RSC_RUN;
                end
                default: begin
                    nxt_st.state = rsc_pkg::RSC_HELD;
                end
            endcase
        end

        // Read data captured in setup so it stands in the access phase
        // Keeps prdata a flop output with no decode on the output path
        if (rd_setup) begin
            case (paddr)
                `RSC_OFS_CAUSE: begin
                    nxt_st.rdata = {24'h000000, st_ff.clr_req, 4'h0,
                                    st_ff.cause};
                end
                `RSC_OFS_SYS3: begin
                    nxt_st.rdata = {31'h00000000, st_ff.pin_dis};
                end
                `RSC_OFS_STATE: begin
                    nxt_st.rdata = {27'h0000000, st_ff.pin_port,
                                    st_ff.int_cnt != 4'h0, ext_rst,
                                    st_ff.state};
                end
                default: begin
                    nxt_st.rdata = 32'h00000000;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_ff <= '{state: rsc_pkg::RSC_HELD, por_q: 1'b1,
                       port_q: 1'b1, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata            = st_ff.rdata;
    assign por_active        = st_ff.por_q;
    assign cpu_hold          = st_ff.state != rsc_pkg::RSC_RUN;
    assign warmup_active     = st_ff.state == rsc_pkg::RSC_WARMUP;
    assign shadow_copy_req   = st_ff.state == rsc_pkg::RSC_SHADOW;
    assign cpu_run           = st_ff.state == rsc_pkg::RSC_RUN;
    assign reset_vector      = `RSC_VECTOR;
    assign reset_pin_is_port = st_ff.pin_port;
    // Port value only meaningful once the pin is a port
    assign port_pin_value    = st_ff.pin_port & st_ff.port_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_por_hold: assert property (
        !supply_good |=> por_active && cpu_hold && !cpu_run)
        else $error("supply low did not hold reset");

    a_pin_reset: assert property (
        pin_rst |=> st_ff.state == rsc_pkg::RSC_HELD && cpu_hold)
        else $error("filtered pin low did not reset");

    a_warm_start: assert property (
        st_ff.state == rsc_pkg::RSC_HELD && !any_rst
        |=> warmup_active && st_ff.warm_cnt == 16'h0000)
        else $error("warm-up did not start on release");

    a_run_gate: assert property (
        $rose(cpu_run) |-> $past(shadow_copy_req) && $past(shadow_copy_done))
        else $error("cpu released before copy done");

    a_pin_filter: assert property (
        pin_low && st_ff.pin_cnt < 16'(PIN_LOW_CYCLES - 1)
        |=> st_ff.pin_cnt == $past(st_ff.pin_cnt) + 16'h0001)
        else $error("pin filter count wrong");

    a_por_pinfn: assert property (
        !supply_good |=> !reset_pin_is_port)
        else $error("pin not reset function after power-up");

    a_cause_set: assert property (
        int_evt && !ext_rst |=> (st_ff.cause & $past(events)) == $past(events))
        else $error("cause flag not recorded");

    a_cause_ext: assert property (
        ext_rst |=> st_ff.cause == 3'h0 && !st_ff.clr_req)
        else $error("cause flags survived pin or power reset");

    a_commit_clr: assert property (
        commit_clr && !int_evt && !ext_rst
        |=> st_ff.cause == 3'h0 && !st_ff.clr_req)
        else $error("clear commit failed");

    a_pin_commit: assert property (
        commit_pin && supply_good |=> reset_pin_is_port == $past(st_ff.pin_dis))
        else $error("pin function not committed");

    a_warm_restart: assert property (
        (warmup_active || shadow_copy_req) && any_rst
        |=> st_ff.state == rsc_pkg::RSC_HELD ##1 !cpu_run)
        else $error("reset during warm-up did not restart");

    a_vector_run: assert property (
        cpu_run |-> reset_vector == 17'h1FFFE)
        else $error("wrong reset vector");

    a_bad_code: assert property (
        commit_wr && !commit_clr && !commit_pin && supply_good && !ext_rst
        |=> $stable(reset_pin_is_port) && (st_ff.cause & $past(st_ff.cause))
            == $past(st_ff.cause))
        else $error("wrong code changed state");

    a_flag_sticky: assert property (
        st_ff.cause != 3'h0 && !ext_rst && !commit_clr
        |=> (st_ff.cause & $past(st_ff.cause)) == $past(st_ff.cause))
        else $error("cause flag dropped on its own");

    a_por_release: assert property (
        supply_good |=> !por_active)
        else $error("power-on reset not released");

    a_int_stretch: assert property (
        int_evt |=> st_ff.int_cnt == `RSC_INT_RST_CYC && cpu_hold)
        else $error("internal reset not stretched");

    a_warm_len: assert property (
        $rose(shadow_copy_req)
        |-> $past(st_ff.warm_cnt) == 16'(WARMUP_CYCLES - 1))
        else $error("warm-up length wrong");

    a_shadow_wait: assert property (
        shadow_copy_req && !shadow_copy_done && !any_rst
        |=> shadow_copy_req && !cpu_run)
        else $error("cpu released before shadow copy");

    a_clr_write: assert property (
        wr_acc && paddr == `RSC_OFS_CAUSE && !ext_rst
        |=> st_ff.clr_req == $past(pwdata[`RSC_BIT_CLR]))
        else $error("clear request not written");

    a_read_cause: assert property (
        psel && penable && !pwrite && paddr == `RSC_OFS_CAUSE
        |-> prdata == {24'h000000, $past(st_ff.clr_req), 4'h0,
                       $past(st_ff.cause)})
        else $error("cause read data wrong");

    c_boot_run: cover property ($rose(cpu_run));
    c_int_reset: cover property (cpu_run && int_evt ##[1:8] cpu_hold);
    c_cause_clear: cover property (commit_clr);
    c_pin_port: cover property ($rose(reset_pin_is_port));
    c_warm_restart: cover property (warmup_active && any_rst);

endmodule : rsc_ctrl

// >>> bench/rsc_pin_model.sv
// Model of the external supervisor on the shared reset pin
`timescale 1ns/1ps
module rsc_pin_model (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Request: hold the pin low for a count of cycles
    input  wire logic        start,
    input  wire logic [15:0] low_len,
    // Pin level seen by the device
    output logic             pin
);
    logic [15:0] cnt_ff;

    // Low time counts down; low_len gives prompt or slow release
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_ff <= 16'h0000;
        end else if (start) begin
            cnt_ff <= low_len;
        end else if (cnt_ff != 16'h0000) begin
            cnt_ff <= cnt_ff - 16'h0001;
        end
    end

    // Released pin rises through the pull-up, never floats
    assign pin = (cnt_ff == 16'h0000);
endmodule : rsc_pin_model

// >>> bench/reset_source_controller_tb_top.sv
// Self-checking testbench of the reset source controller
`timescale 1ns/1ps
`include "rsc_cfg.svh"
module reset_source_controller_tb_top;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    localparam int WARM = 8;
    localparam int PLOW = 4;
    logic        clock, rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        supply_good, pin, pin_start, vdet, wdt, dead, sh_req;
    logic        sh_done = 1'b0;
    logic        por_active, cpu_hold, warm, cpu_run, is_port, port_val;
    logic [16:0] vec;
    logic [15:0] pin_len;
    logic [32:0] expq[$];
    int          num_errors, comparisons, cycles, seed, n, i;

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    rsc_ctrl #(.WARMUP_CYCLES(WARM), .PIN_LOW_CYCLES(PLOW)) DUT (
        .clock(clock), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .supply_good(supply_good), .shared_reset_port_pin(pin),
        .vdet_reset_req(vdet), .wdt_overflow(wdt),
        .clock_deadlock_flag(dead), .shadow_copy_done(sh_done),
        .shadow_copy_req(sh_req), .por_active(por_active),
        .cpu_hold(cpu_hold), .warmup_active(warm), .cpu_run(cpu_run),
        .reset_vector(vec), .reset_pin_is_port(is_port),
        .port_pin_value(port_val));

    rsc_pin_model PIN (.clock(clock), .rst(rst), .start(pin_start),
        .low_len(pin_len), .pin(pin));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task chk(input string nm, input logic [32:0] got,
             input logic [32:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask : chk

    // One APB transfer; idle edge after it keeps drivers race free
    task bus(input logic [11:0] a, input logic w, input logic [31:0] d,
             input logic [32:0] e);
        if (!w) expq.push_back(e);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : bus

    task ev(input int k);
        {dead, wdt, vdet} <= 3'h1 << k;
        @(posedge clock);
        {dead, wdt, vdet} <= 3'h0;
    endtask : ev

    task pin_low(input logic [15:0] len);
        pin_len   <= len;
        pin_start <= 1'b1;
        @(posedge clock);
        pin_start <= 1'b0;
    endtask : pin_low

    // Count warm-up cycles, then wait for release of the CPU
    task run_seq(output int c);
        c = 0;
        repeat (2) @(posedge clock);
        while (warm !== 1'b1) @(posedge clock);
        while (warm === 1'b1) begin
            c++;
            @(posedge clock);
        end
        while (cpu_run !== 1'b1) @(posedge clock);
    endtask : run_seq

    task tally_and_finish;
        if (expq.size() != 0) num_errors++;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish

    // Reads finish here: oldest note against what the bus returned
    always @(posedge clock) begin
        if (psel && penable && pready && !pwrite && expq.size() > 0)
            chk("read", {pslverr, prdata}, expq.pop_front());
    end

    // Shadow copy finishes after a random delay
    always @(posedge clock) sh_done <= sh_req && ($random(seed) & 1);

    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish;
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 44'h0};
        {supply_good, pin_start, pin_len, vdet, wdt, dead} = 21'h0;
        {seed, num_errors, comparisons, cycles} = {32'd68, 96'h0};
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        // Pin held low past the supply release
        pin_low(16'h0028);
        repeat (3) @(posedge clock);
        chk("por", por_active, 1'b1);
        chk("hold", cpu_hold, 1'b1);
        chk("vector", vec, `RSC_VECTOR);
        supply_good <= 1'b1;
        repeat (12) @(posedge clock);
        chk("warm early", warm, 1'b0);
        run_seq(n);
        chk("warm len", n, WARM);
        chk("pin mode", is_port, 1'b0);
        bus(`RSC_OFS_CAUSE, 1'b0, 32'h0, 33'h0);
        // Internal factors; flags pile up, all kept
        for (i = 0; i < 3; i++) begin
            ev(i);
            @(posedge clock);
            chk("ev hold", cpu_hold, 1'b1);
            run_seq(n);
            chk("ev warm", n, WARM);
            bus(`RSC_OFS_CAUSE, 1'b0, 0, (33'h2 << i) - 1);
        end
        // Second source in mid warm-up restarts the count
        ev(1);
        repeat (2) @(posedge clock);
        while (warm !== 1'b1) @(posedge clock);
        repeat (3) @(posedge clock);
        ev(0);
        run_seq(n);
        chk("restart", n, WARM);
        // Wrong code, then the clear code
        bus(`RSC_OFS_CAUSE, 1'b1, 32'h00000080, 33'h0);
        bus(`RSC_OFS_COMMIT, 1'b1, 32'h00000072, 33'h0);
        bus(`RSC_OFS_CAUSE, 1'b0, 32'h0, 33'h87);
        bus(`RSC_OFS_CAUSE, 1'b1, 32'h00000080, 33'h0);
        bus(`RSC_OFS_COMMIT, 1'b1, `RSC_CODE_CLR, 33'h0);
        bus(`RSC_OFS_CAUSE, 1'b0, 32'h0, 33'h0);
        bus(`RSC_OFS_COMMIT, 1'b0, 32'h0, 33'h0);
        bus(12'h010, 1'b0, 32'h0, 33'h100000000);
        // Pin low one short of the filter, then long enough
        ev(2);
        run_seq(n);
        pin_low(16'(PLOW - 1));
        repeat (10) @(posedge clock);
        chk("short low", cpu_run, 1'b1);
        pin_low(16'(PLOW));
        repeat (PLOW + 3) @(posedge clock);
        chk("pin reset", cpu_hold, 1'b1);
        run_seq(n);
        bus(`RSC_OFS_CAUSE, 1'b0, 32'h0, 33'h0);
        // Pin turned into a port and back
        bus(`RSC_OFS_SYS3, 1'b1, $random(seed) | 1, 33'h0);
        bus(`RSC_OFS_COMMIT, 1'b1, 32'h00000033, 33'h0);
        chk("bad code", is_port, 1'b0);
        bus(`RSC_OFS_COMMIT, 1'b1, `RSC_CODE_PIN, 33'h0);
        @(posedge clock);
        chk("to port", is_port, 1'b1);
        pin_low(16'h0008);
        repeat (4) @(posedge clock);
        chk("port low", port_val, 1'b0);
        repeat (10) @(posedge clock);
        chk("port run", cpu_run, 1'b1);
        chk("port high", port_val, 1'b1);
        bus(`RSC_OFS_SYS3, 1'b1, $random(seed) & 32'hFFFFFFFE, 33'h0);
        bus(`RSC_OFS_COMMIT, 1'b1, `RSC_CODE_PIN, 33'h0);
        @(posedge clock);
        chk("to reset", is_port, 1'b0);
        // Supply drop clears flags and the port mode
        ev(0);
        run_seq(n);
        bus(`RSC_OFS_SYS3, 1'b1, 32'h00000001, 33'h0);
        bus(`RSC_OFS_COMMIT, 1'b1, `RSC_CODE_PIN, 33'h0);
        supply_good <= 1'b0;
        repeat (5) @(posedge clock);
        chk("por again", por_active, 1'b1);
        chk("por hold", cpu_hold, 1'b1);
        supply_good <= 1'b1;
        run_seq(n);
        chk("por mode", is_port, 1'b0);
        bus(`RSC_OFS_CAUSE, 1'b0, 32'h0, 33'h0);
        tally_and_finish;
    end
endmodule : reset_source_controller_tb_top
